// >>> pcra_pkg.sv
// Package of constants for the pseudo-static memory configuration controller
package pcra_pkg;
	// ==========================================
	// Pin widths and addresses
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam logic [21:0] TOP_ADDR = 22'h3FFFFF;
	localparam logic [21:0] CFG_DEFAULT = 22'h000070;
	// ==========================================
	// Configuration word fields
	localparam int CFG_PAGE_BIT = 7;
	localparam int CFG_TCR_LO = 5;
	localparam int CFG_SLEEP_BIT = 4;
	localparam int CFG_PAR_LO = 0;
	localparam logic [21:0] CFG_LEGAL_MASK = 22'h0000F7;
	localparam logic [1:0] TCR_85C = 2'h3;
	localparam logic [1:0] TCR_70C = 2'h0;
	localparam logic [1:0] TCR_45C = 2'h1;
	localparam logic [1:0] TCR_15C = 2'h2;
	localparam logic [2:0] PAR_FULL = 3'h0;
	localparam logic [2:0] PAR_NONE = 3'h4;
	// ==========================================
	// Controller register offsets and command codes
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_WDATA = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_RDATA = 4'h3;
	localparam logic [3:0] REG_SHADOW = 4'h4;
	localparam logic [1:0] CMD_SW_LOAD = 2'h1;
	localparam logic [1:0] CMD_SW_READ = 2'h2;
	localparam logic [1:0] CMD_ZZ_LOAD = 2'h3;
	// ==========================================
	// Timing, 200 MHz clock
	localparam int CLK_MHZ = 200;
	localparam int T_CYCLE_NS = 80;
	localparam int T_CYCLE_CYC = (T_CYCLE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_ZZWE_NS = 50;
	localparam int T_ZZWE_CYC = (T_ZZWE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_ZZ_US = 11;
	localparam int T_ZZ_CYC = T_ZZ_US * CLK_MHZ;
	localparam int T_INIT_US = 150;
	localparam int T_INIT_CYC = T_INIT_US * CLK_MHZ;
	typedef enum logic [7:0] {
		PCRA_IDLE = 8'h01,
		PCRA_SETUP = 8'h02,
		PCRA_STROBE = 8'h04,
		PCRA_GAP = 8'h08,
		PCRA_ZZ_FALL = 8'h10,
		PCRA_SLEEP = 8'h20,
		PCRA_INIT = 8'h40,
		PCRA_DONE = 8'h80
	} pcra_state_e;
endpackage

// >>> pcra_timer.sv
// Down counter that pulses done when a loaded cycle count runs out
`timescale 1ns/1ps
module pcra_timer #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic load,
	input wire logic [W-1:0] count,
	output logic done
);
	logic [W-1:0] cnt;
	logic run;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
			run <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				cnt <= count;
				run <= 1'b1;
			end else if (run) begin
				if (cnt <= {{(W-1){1'b0}}, 1'b1}) begin
					run <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// >>> pcra_ctrl.sv
// Host controller loading and reading the memory configuration word
// Function
// - Software load: two reads then two writes, last write carries new word.
// - Software read: two reads, one write, then a read returning the word.
// - Every cycle of the software sequence addresses 3FFFFFh.
// - Host writes zero to reserved bits 21..8 and bit 3.
// - Deep powerdown changes only via sleep-pin load, not software.
// - After deep powerdown exit wait 150us before normal access.
// - Host programs temperature setting at or above case temperature.
// - Sleep-pin load: write after sleep pin falls, address lines give word.
// - Sleep pin low over 10us enters mode chosen by bit 4; the controller lets software release it sooner.
`timescale 1ns/1ps
module pcra_ctrl
	import pcra_pkg::*;
#(
	parameter int ZZ_CYC = pcra_pkg::T_ZZ_CYC,
	parameter int INIT_CYC = pcra_pkg::T_INIT_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [pcra_pkg::ADDR_W-1:0] mem_addr,
	output logic [pcra_pkg::DATA_W-1:0] mem_dq_out,
	output logic mem_dq_oe,
	input wire logic [pcra_pkg::DATA_W-1:0] mem_dq_in,
	output logic mem_ce_n,
	output logic mem_oe_n,
	output logic mem_we_n,
	output logic mem_lb_n,
	output logic mem_ub_n,
	output logic sleep_pin_n
);
	import pcra_pkg::*;
	// ==========================================
	// Register decode
	logic [21:0] wdata;
	logic [21:0] shadow;
	logic [15:0] rdata;
	logic busy;
	logic sw_loaded;
	logic init_wait;
	logic [1:0] cmd;
	logic sleep_req;
	logic [1:0] step;
	logic [7:0] ph_cnt;
	pcra_state_e state;
	pcra_state_e next_state;
	wire wr_ctrl = reg_wr && reg_addr == REG_CTRL;
	wire wr_wdata = reg_wr && reg_addr == REG_WDATA;
	wire [1:0] ctrl_cmd = reg_wdata[1:0];
	// Deep powerdown bit cannot change by software load; keep current bit 4
	wire cmd_illegal = ctrl_cmd == CMD_SW_LOAD && wdata[CFG_SLEEP_BIT] != shadow[CFG_SLEEP_BIT];
	// Sleep entry wins over a command carried in the same write
	wire start = wr_ctrl && !busy && ctrl_cmd != 2'h0 && !cmd_illegal && !reg_wdata[2];
	wire sleep_start = wr_ctrl && !busy && reg_wdata[2];
	wire [21:0] wclean = wdata & CFG_LEGAL_MASK;
	// Step 2 is a write for both kinds; step 3 is write for load, read for read
	wire step_is_wr = step == 2'h2 || (step == 2'h3 && cmd == CMD_SW_LOAD);
	wire ph_done = ph_cnt == 8'h00;
	wire [31:0] status_word = {24'h0, 3'h0, init_wait, sw_loaded, state == PCRA_SLEEP, 1'b0, busy};
	wire [2:0] par_field = shadow[CFG_PAR_LO+2:CFG_PAR_LO];
	wire par_none = par_field == PAR_NONE;
	wire [31:0] shadow_word = {par_none, 23'h0, shadow[7:0]};
	logic timer_load;
	logic [15:0] timer_count;
	logic timer_done;
	pcra_timer #(.W(16)) pcra_timer_i (
		.clk(clk),
		.rstn(rstn),
		.load(timer_load),
		.count(timer_count),
		.done(timer_done)
	);
	// ==========================================
	// Sequencer
	always_comb begin
		next_state = state;
		timer_load = 1'b0;
		timer_count = 16'(ZZ_CYC);
		unique case (state)
			PCRA_IDLE: begin
				if (sleep_start) begin
					next_state = PCRA_SLEEP;
					timer_load = 1'b1;
				end else if (start) begin
					next_state = ctrl_cmd == CMD_ZZ_LOAD ? PCRA_ZZ_FALL : PCRA_SETUP;
				end
			end
			PCRA_SETUP: if (ph_done) next_state = PCRA_STROBE;
			PCRA_STROBE: if (ph_done) next_state = PCRA_GAP;
			PCRA_GAP: begin
				if (ph_done) next_state = (cmd == CMD_ZZ_LOAD || step == 2'h3) ? PCRA_DONE
					: PCRA_SETUP;
			end
			PCRA_ZZ_FALL: if (ph_done) next_state = PCRA_STROBE;
			PCRA_SLEEP: begin
				// Sleep pin held low until software releases it; the minimum low time is not checked
				if (wr_ctrl && reg_wdata[3]) begin
					next_state = PCRA_INIT;
					timer_load = 1'b1;
					timer_count = 16'(INIT_CYC);
				end
			end
			PCRA_INIT: if (timer_done || !init_wait) next_state = PCRA_DONE;
			PCRA_DONE: next_state = PCRA_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= PCRA_IDLE;
			cmd <= 2'h0;
			step <= 2'h0;
			ph_cnt <= 8'h00;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			ph_cnt <= ph_done ? 8'h00 : ph_cnt - 8'h01;
			if (state == PCRA_IDLE && start) begin
				cmd <= ctrl_cmd;
				step <= 2'h0;
				busy <= 1'b1;
				ph_cnt <= ctrl_cmd == CMD_ZZ_LOAD ? 8'(T_ZZWE_CYC) : 8'h01;
			end else if (state == PCRA_IDLE && sleep_start) begin
				// No command, so leaving sleep loads no stale staged word
				cmd <= 2'h0;
				busy <= 1'b1;
			end else if (next_state == PCRA_STROBE && state != PCRA_STROBE) begin
				ph_cnt <= 8'(T_CYCLE_CYC);
			end else if (next_state == PCRA_GAP && state != PCRA_GAP) begin
				ph_cnt <= 8'h02;
			end else if (state == PCRA_GAP && next_state == PCRA_SETUP) begin
				step <= step + 2'h1;
				ph_cnt <= 8'h01;
			end
			if (state == PCRA_DONE) begin
				busy <= 1'b0;
			end
		end
	end
	// ==========================================
	// Memory pins
	wire strobing = state == PCRA_STROBE;
	wire in_seq = state == PCRA_SETUP || strobing || state == PCRA_GAP;
	wire zz_low = state == PCRA_ZZ_FALL || state == PCRA_SLEEP
		|| (cmd == CMD_ZZ_LOAD && (strobing || state == PCRA_GAP));
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mem_addr <= 22'h0;
			mem_dq_out <= 16'h0;
			mem_dq_oe <= 1'b0;
			mem_ce_n <= 1'b1;
			mem_oe_n <= 1'b1;
			mem_we_n <= 1'b1;
			mem_lb_n <= 1'b1;
			mem_ub_n <= 1'b1;
			sleep_pin_n <= 1'b1;
		end else begin
			sleep_pin_n <= !zz_low;
			if (cmd == CMD_ZZ_LOAD && in_seq) begin
				mem_addr <= wclean;
			end else begin
				mem_addr <= TOP_ADDR;
			end
			mem_ce_n <= !(strobing && !ph_done);
			mem_we_n <= !(strobing && !ph_done && (step_is_wr || cmd == CMD_ZZ_LOAD));
			mem_oe_n <= !(strobing && !ph_done && !step_is_wr && cmd != CMD_ZZ_LOAD);
			mem_lb_n <= !(strobing && !ph_done && cmd != CMD_ZZ_LOAD);
			mem_ub_n <= !(strobing && !ph_done && cmd != CMD_ZZ_LOAD);
			mem_dq_oe <= in_seq && step_is_wr && cmd != CMD_ZZ_LOAD;
			// Third step writes the current word back so nothing changes
			mem_dq_out <= step == 2'h3 ? wclean[15:0] : shadow[15:0];
		end
	end
	// ==========================================
	// Shadow of configuration word and flags
	wire rd_capture = strobing && ph_cnt == 8'h01 && step == 2'h3 && cmd == CMD_SW_READ;
	wire load_done = state == PCRA_DONE && (cmd == CMD_SW_LOAD || cmd == CMD_ZZ_LOAD);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// Staged word starts at the hottest refresh setting, the safe choice
			wdata <= CFG_DEFAULT;
			shadow <= CFG_DEFAULT;
			rdata <= 16'h0;
			sw_loaded <= 1'b0;
			init_wait <= 1'b0;
		end else begin
			if (wr_wdata && !busy) begin
				wdata <= reg_wdata[21:0];
			end
			if (rd_capture) begin
				rdata <= mem_dq_in;
			end
			if (load_done) begin
				shadow <= wclean;
			end
			if (load_done && cmd == CMD_SW_LOAD) begin
				sw_loaded <= 1'b1;
			end
			// Releasing the pin from deep powerdown needs the full init wait
			if (state == PCRA_SLEEP && next_state == PCRA_INIT) begin
				init_wait <= !shadow[CFG_SLEEP_BIT] || sw_loaded;
			end else if (timer_done) begin
				init_wait <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_WDATA: reg_rdata <= {10'h0, wdata};
				REG_STATUS: reg_rdata <= status_word;
				REG_RDATA: reg_rdata <= {16'h0, rdata};
				REG_SHADOW: reg_rdata <= shadow_word;
				default: reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end
endmodule

// >>> pcra_ctrl_props.sv
// Checker of the controller's memory pin behaviour
`timescale 1ns/1ps
module pcra_ctrl_props
	import pcra_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [pcra_pkg::ADDR_W-1:0] mem_addr,
	input wire logic mem_dq_oe,
	input wire logic mem_ce_n,
	input wire logic mem_oe_n,
	input wire logic mem_we_n,
	input wire logic mem_lb_n,
	input wire logic mem_ub_n,
	input wire logic sleep_pin_n
);
	import pcra_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// ==========================================
	// Pin relations
	property p_top; !mem_ce_n && sleep_pin_n |-> mem_addr == TOP_ADDR; endproperty
	a_top: assert property (p_top) else $error("strobe off top address");
	property p_rdbus; !mem_ce_n && !mem_oe_n && mem_we_n |-> !mem_dq_oe; endproperty
	a_rdbus: assert property (p_rdbus) else $error("bus driven in read");
	property p_wrbus; !mem_we_n && sleep_pin_n |-> mem_dq_oe; endproperty
	a_wrbus: assert property (p_wrbus) else $error("bus idle in write");
	property p_pulse; $fell(mem_ce_n) |=> !mem_ce_n [*8]; endproperty
	a_pulse: assert property (p_pulse) else $error("strobe too short");
	property p_gap; $rose(mem_ce_n) |-> mem_ce_n [*3]; endproperty
	a_gap: assert property (p_gap) else $error("gap too short");
	property p_zzwe; $fell(sleep_pin_n) |-> mem_we_n [*2]; endproperty
	a_zzwe: assert property (p_zzwe) else $error("write too soon after sleep");
	property p_cdzz; $fell(sleep_pin_n) |-> $past(mem_ce_n); endproperty
	a_cdzz: assert property (p_cdzz) else $error("sleep while selected");
	property p_noread; !sleep_pin_n |-> mem_oe_n; endproperty
	a_noread: assert property (p_noread) else $error("read while asleep");
	property p_bytes; !mem_ce_n && sleep_pin_n |-> !mem_lb_n && !mem_ub_n; endproperty
	a_bytes: assert property (p_bytes) else $error("byte lanes off in access");
endmodule
bind pcra_ctrl pcra_ctrl_props pcra_ctrl_props_i (.clk, .rstn, .mem_addr, .mem_dq_oe, .mem_ce_n,
	.mem_oe_n, .mem_we_n, .mem_lb_n, .mem_ub_n, .sleep_pin_n);

// >>> pcra_mem_model.sv
// Behavioural pseudo-static memory answering configuration sequences
`timescale 1ns/1ps
module pcra_mem_model
	import pcra_pkg::*;
(
	input wire logic mem_ce_n,
	input wire logic mem_oe_n,
	input wire logic mem_we_n,
	input wire logic sleep_pin_n,
	input wire logic [pcra_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [pcra_pkg::DATA_W-1:0] mem_dq_out,
	output logic [pcra_pkg::DATA_W-1:0] mem_dq_in,
	output logic [pcra_pkg::ADDR_W-1:0] cfg
);
	import pcra_pkg::*;
	// Array word at the top address; the sequence never writes it
	localparam logic [15:0] TOP_WORD = 16'hA55A;
	logic [1:0] step = 2'h0;
	logic wrote = 1'b0;
	wire reading = !mem_ce_n && !mem_oe_n && mem_we_n;
	initial cfg = CFG_DEFAULT;
	// Released bus shows the inverse word, so a late sample is caught
	assign mem_dq_in = !reading ? ~cfg[15:0] : (step == 2'h3 ? cfg[15:0] : TOP_WORD);
	always @(negedge mem_we_n) wrote = 1'b1;
	always @(posedge mem_ce_n) begin
		if (sleep_pin_n === 1'b0) begin
			cfg = mem_addr;
			step = 2'h0;
		end else if (mem_addr !== TOP_ADDR || (step < 2'h2 ? wrote : (step == 2'h2 && !wrote))) begin
			step = 2'h0;
		end else begin
			if (step == 2'h3 && wrote)
				cfg[15:0] = mem_dq_out;
			step = step + 2'h1;
		end
		wrote = 1'b0;
	end
endmodule

// >>> pcra_ctrl_tb.sv
// Self-checking bench for the configuration controller
`timescale 1ns/1ps
module pcra_ctrl_tb;
	import pcra_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [21:0] mem_addr;
	logic [21:0] cfg;
	logic [15:0] mem_dq_out;
	logic [15:0] mem_dq_in;
	logic mem_dq_oe, mem_ce_n, mem_oe_n, mem_we_n, sleep_pin_n;
	int bad_count = 0;
	int compares = 0;
	// Short sleep and init counts keep the run brief
	pcra_ctrl #(.ZZ_CYC(20), .INIT_CYC(50)) pcra_ctrl_i (.clk, .rstn, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .mem_addr, .mem_dq_out, .mem_dq_oe, .mem_dq_in, .mem_ce_n,
		.mem_oe_n, .mem_we_n, .mem_lb_n(), .mem_ub_n(), .sleep_pin_n);
	pcra_mem_model pcra_mem_model_i (.mem_ce_n, .mem_oe_n, .mem_we_n, .sleep_pin_n, .mem_addr,
		.mem_dq_out, .mem_dq_in, .cfg);
	initial forever #2.5 clk = ~clk;
	// ==========================================
	// Bus tasks
	task automatic give_verdict;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
		compares++;
		if (got !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, e, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic get(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input string what);
		logic [31:0] v;
		get(a, v);
		chk(what, e, v);
	endtask
	// Busy and init wait both block the next command
	task automatic wait_idle;
		logic [31:0] s;
		s = 32'h1;
		for (int n = 0; n < 500 && (s[0] !== 1'b0 || s[4] !== 1'b0); n++)
			get(REG_STATUS, s);
		if (s[0] !== 1'b0 || s[4] !== 1'b0) begin
			chk("idle status", 32'h0, s & 32'h11);
			give_verdict();
		end
	endtask
	task automatic run(input logic [1:0] c, input logic [31:0] w);
		wr(REG_WDATA, w);
		wr(REG_CTRL, {30'h0, c});
		wait_idle();
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset;
		rd(REG_SHADOW, 32'h70, "shadow");
		chk("cfg", 32'h70, {10'h0, cfg});
		rd(4'hF, 32'h0, "unmapped");
		$display("test reset done");
	endtask
	task automatic t_sw;
		run(CMD_SW_LOAD, 32'hD1);
		chk("cfg", 32'hD1, {10'h0, cfg});
		rd(REG_STATUS, 32'h8, "status");
		run(CMD_SW_READ, 32'h0);
		rd(REG_RDATA, 32'hD1, "rdata");
		run(CMD_SW_LOAD, 32'hC1);
		chk("cfg", 32'hD1, {10'h0, cfg});
		$display("test software access done");
	endtask
	task automatic t_zz;
		run(CMD_ZZ_LOAD, 32'h64);
		chk("cfg", 32'h64, {10'h0, cfg});
		rd(REG_SHADOW, 32'h80000064, "shadow");
		// Every temperature code, reserved bits set on input
		for (int k = 0; k < 4; k++) begin
			run(CMD_SW_LOAD, (k << 5) | (k[0] ? 32'h4 : 32'h0) | 32'h3FFF08);
			chk("cfg", (k << 5) | (k[0] ? 32'h4 : 32'h0), {10'h0, cfg});
		end
		$display("test pin load done");
	endtask
	task automatic t_sleep;
		logic [31:0] v;
		// A staged word that must not be loaded by leaving sleep
		wr(REG_WDATA, 32'h24);
		wr(REG_CTRL, 32'h4);
		rd(REG_STATUS, 32'hD, "status");
		chk("sleep pin", 32'h0, {31'h0, sleep_pin_n});
		repeat (25) @(posedge clk);
		wr(REG_CTRL, 32'h8);
		get(REG_STATUS, v);
		chk("init wait", 32'h1, {31'h0, v[4]});
		wait_idle();
		chk("sleep pin", 32'h1, {31'h0, sleep_pin_n});
		rd(REG_SHADOW, 32'h80000064, "shadow");
		chk("cfg", 32'h64, {10'h0, cfg});
		$display("test deep sleep done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_sw();
		t_zz();
		t_sleep();
		give_verdict();
	end
endmodule
